//--- core/sto_seq.sv
`timescale 1ns/1ps
`include "sto_params.svh"
// Behaviour
// - cutoff drops servo ready, enters cutoff status
// - cutoff status never raises alarm
// - display shows St during cutoff
// - auto return when inputs on, servo-on off
// - monitor output on within 6 ms
// - brake release drops on delay or speed
// - dynamic brake follows alarm stop sequence
// - no alarm clear needed to return
// - release uses servo-off stop sequence
// - ready again about 20 ms after return
// - normal servo timing after servo-on
// - alarm deceleration applies without alarm
// - power-up with inputs off starts in cutoff
// - torque cut within 5 ms
// - off pulses of 1 ms ignored
// - monitor on only when both inputs off
module sto_seq #(
  parameter int FILT_CYC = (`STO_FILT_US * (`STO_CLK_HZ / 1000000)) + 1,
  parameter int RDY_CYC  = `STO_RDY_US * (`STO_CLK_HZ / 1000000),
  parameter int TICK_CYC = `STO_CLK_HZ / 1000
) (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic                    safety_input_one,
  input  wire logic                    safety_input_two,
  input  wire logic                    servo_on_input,
  input  wire logic [`STO_SPD_W-1:0]   motor_speed,
  input  wire logic [`STO_SPD_W-1:0]   brake_release_speed_threshold,
  input  wire logic [`STO_TIM_W-1:0]   brake_action_delay_time,
  input  wire logic [`STO_SEQ_W-1:0]   alarm_stop_sequence,
  input  wire logic [`STO_SEQ_W-1:0]   servo_off_stop_sequence,
  output logic                         servo_ready,
  output logic                         motor_energize,
  output logic                         external_monitor_output,
  output logic                         brake_release_output,
  output logic                         safe_torque_cutoff,
  output logic                         alarm_active,
  output logic [`STO_SEQ_W-1:0]        stop_sequence,
  output logic [7:0]                   seg_left,
  output logic [7:0]                   seg_right
);
  import sto_pkg::*;

  typedef struct packed {
    logic [1:0]              s1_sync;
    logic [1:0]              s2_sync;
    logic [1:0]              son_sync;
    logic                    s1_filt;
    logic                    s2_filt;
    logic [`STO_CNT_W-1:0]   f1_cnt;
    logic [`STO_CNT_W-1:0]   f2_cnt;
    sto_state_e              state;
    logic [`STO_CNT_W-1:0]   rdy_cnt;
    logic [`STO_CNT_W-1:0]   tick_cnt;
    logic [`STO_TIM_W-1:0]   ms_cnt;
    logic                    servo_ready;
    logic                    motor_energize;
    logic                    monitor;
    logic                    brake_rel;
    logic                    cutoff;
    logic [`STO_SEQ_W-1:0]   stop_seq;
    logic [7:0]              seg_l;
    logic [7:0]              seg_r;
    logic                    alarm;
    // watch counters, read only by the latency checks
    logic [`STO_CNT_W-1:0]   off_cnt;
    logic [`STO_CNT_W-1:0]   mon_cnt;
  } sto_reg_s;

  sto_reg_s r;
  sto_reg_s next_r;

  // off pulse must outlast the filter before it counts as off
  function automatic logic [`STO_CNT_W-1:0] filt_step(input logic in_off,
                                                     input logic [`STO_CNT_W-1:0] cnt);
    if (!in_off)
      filt_step = '0;
    else if (cnt < `STO_CNT_W'(FILT_CYC))
      filt_step = cnt + `STO_CNT_W'(1);
    else
      filt_step = cnt;
  endfunction

  // one pattern per digit while cut, blank otherwise
  function automatic logic [7:0] seg_pick(input logic       cut_on,
                                          input logic [7:0] pat);
    if (cut_on)
      seg_pick = pat;
    else
      seg_pick = `STO_SEG_BLANK;
  endfunction

  logic both_off;
  logic both_on;
  logic son;
  assign both_off = !r.s1_filt && !r.s2_filt;
  assign both_on  = r.s1_filt && r.s2_filt;
  assign son      = r.son_sync[1];

  always_comb begin
    next_r = r;
    next_r.s1_sync  = {r.s1_sync[0], safety_input_one};
    next_r.s2_sync  = {r.s2_sync[0], safety_input_two};
    next_r.son_sync = {r.son_sync[0], servo_on_input};
    next_r.f1_cnt = filt_step(!r.s1_sync[1], r.f1_cnt);
    next_r.f2_cnt = filt_step(!r.s2_sync[1], r.f2_cnt);
    if (r.s1_sync[1])
      next_r.s1_filt = 1'b1;
    else if (r.f1_cnt >= `STO_CNT_W'(FILT_CYC))
      next_r.s1_filt = 1'b0;
    if (r.s2_sync[1])
      next_r.s2_filt = 1'b1;
    else if (r.f2_cnt >= `STO_CNT_W'(FILT_CYC))
      next_r.s2_filt = 1'b0;
    next_r.monitor = both_off;
    if (!r.s1_sync[1] && !r.s2_sync[1] && !r.cutoff) begin
      if (r.off_cnt != '1)
        next_r.off_cnt = r.off_cnt + `STO_CNT_W'(1);
    end else begin
      next_r.off_cnt = '0;
    end
    if (!r.s1_sync[1] && !r.s2_sync[1] && !r.monitor) begin
      if (r.mon_cnt != '1)
        next_r.mon_cnt = r.mon_cnt + `STO_CNT_W'(1);
    end else begin
      next_r.mon_cnt = '0;
    end
    next_r.alarm = 1'b0;
    unique case (r.state)
      STO_RUN: begin
        next_r.stop_seq = servo_off_stop_sequence;
        next_r.motor_energize = son;
        next_r.brake_rel = son;
        next_r.servo_ready = 1'b1;
        if (both_off) begin
          next_r.state = STO_CUT;
          next_r.motor_energize = 1'b0;
          next_r.servo_ready = 1'b0;
          next_r.cutoff = 1'b1;
          next_r.tick_cnt = '0;
          next_r.ms_cnt = '0;
          next_r.stop_seq = alarm_stop_sequence;
        end
      end
      STO_CUT: begin
        next_r.motor_energize = 1'b0;
        next_r.servo_ready = 1'b0;
        next_r.cutoff = 1'b1;
        next_r.stop_seq = alarm_stop_sequence;
        if (r.tick_cnt >= `STO_CNT_W'(TICK_CYC - 1)) begin
          next_r.tick_cnt = '0;
          if (r.ms_cnt != '1)
            next_r.ms_cnt = r.ms_cnt + `STO_TIM_W'(1);
        end else begin
          next_r.tick_cnt = r.tick_cnt + `STO_CNT_W'(1);
        end
        if (r.ms_cnt >= brake_action_delay_time ||
            motor_speed < brake_release_speed_threshold)
          next_r.brake_rel = 1'b0;
        // servo-on must be off, no alarm clear needed
        if (both_on && !son) begin
          next_r.state = STO_RECOV;
          next_r.rdy_cnt = '0;
          next_r.brake_rel = 1'b0;
        end
      end
      STO_RECOV: begin
        next_r.motor_energize = 1'b0;
        next_r.brake_rel = 1'b0;
        next_r.cutoff = 1'b0;
        next_r.stop_seq = servo_off_stop_sequence;
        if (both_off) begin
          next_r.state = STO_CUT;
          next_r.cutoff = 1'b1;
          next_r.tick_cnt = '0;
          next_r.ms_cnt = brake_action_delay_time;
          next_r.stop_seq = alarm_stop_sequence;
        end else if (r.rdy_cnt >= `STO_CNT_W'(RDY_CYC - 1)) begin
          next_r.state = STO_RUN;
          next_r.servo_ready = 1'b1;
        end else begin
          next_r.rdy_cnt = r.rdy_cnt + `STO_CNT_W'(1);
        end
      end
      default: next_r.state = STO_CUT;
    endcase
    next_r.seg_l = seg_pick(next_r.state == STO_CUT, `STO_SEG_S);
    next_r.seg_r = seg_pick(next_r.state == STO_CUT, `STO_SEG_T);
  end

  // reset starts in cutoff; run is reached only through recovery
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '0;
      r.state <= STO_CUT;
      r.cutoff <= 1'b1;
      r.ms_cnt <= '1;
      r.seg_l <= `STO_SEG_S;
      r.seg_r <= `STO_SEG_T;
    end else begin
      r <= next_r;
    end
  end

  assign servo_ready             = r.servo_ready;
  assign motor_energize          = r.motor_energize;
  assign external_monitor_output = r.monitor;
  assign brake_release_output    = r.brake_rel;
  assign safe_torque_cutoff      = r.cutoff;
  assign alarm_active            = r.alarm;
  assign stop_sequence           = r.stop_seq;
  assign seg_left                = r.seg_l;
  assign seg_right               = r.seg_r;

  a_cut_no_energy: assert property (@(posedge mclk) disable iff (!nrst)
    r.cutoff |-> !motor_energize && !servo_ready) else $error("energized in cutoff");
  a_cut_no_alarm: assert property (@(posedge mclk) disable iff (!nrst)
    !alarm_active) else $error("alarm raised");
  a_cut_display: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_CUT) |-> seg_left == `STO_SEG_S && seg_right == `STO_SEG_T)
    else $error("display not St");
  a_mon_logic: assert property (@(posedge mclk) disable iff (!nrst)
    both_off |=> external_monitor_output) else $error("monitor late");
  a_mon_off: assert property (@(posedge mclk) disable iff (!nrst)
    !both_off |=> !external_monitor_output) else $error("monitor wrongly on");
  a_enter_cut: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RUN && both_off) |=> r.state == STO_CUT && !servo_ready)
    else $error("cutoff not entered");
  a_stop_seq: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_CUT && $past(nrst)) |->
      stop_sequence == $past(alarm_stop_sequence))
    else $error("wrong stop sequence");
  a_recov_seq: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RECOV && $past(r.state) == STO_RECOV) |->
      stop_sequence == $past(servo_off_stop_sequence))
    else $error("wrong release sequence");
  a_return_run: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_CUT && both_on && !son) |=> r.state == STO_RECOV)
    else $error("no automatic return");
  a_brake_drop: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_CUT && $past(r.state) == STO_CUT &&
     motor_speed < brake_release_speed_threshold) |=> !brake_release_output)
    else $error("brake not engaged");

  // latency bounds: the filter dominates, the pipeline adds a few cycles
  a_power_up_cut: assert property (@(posedge mclk) disable iff (!nrst)
    !$past(nrst) |-> r.state == STO_CUT && safe_torque_cutoff)
    else $error("not in cutoff after reset");
  a_cut_in_time: assert property (@(posedge mclk) disable iff (!nrst)
    r.off_cnt <= `STO_CNT_W'(FILT_CYC + `STO_PIPE_CYC))
    else $error("torque cut late");
  a_mon_in_time: assert property (@(posedge mclk) disable iff (!nrst)
    r.mon_cnt <= `STO_CNT_W'(FILT_CYC + `STO_PIPE_CYC))
    else $error("monitor output late");
  a_filt_one: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(r.s1_filt) |-> $past(r.f1_cnt) >= `STO_CNT_W'(FILT_CYC))
    else $error("short pulse passed on input one");
  a_filt_two: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(r.s2_filt) |-> $past(r.f2_cnt) >= `STO_CNT_W'(FILT_CYC))
    else $error("short pulse passed on input two");

  // return path and run
  a_son_holds_cut: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_CUT && son) |=> r.state == STO_CUT)
    else $error("left cutoff with servo on");
  a_recov_idle: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RECOV) |-> !motor_energize && !brake_release_output)
    else $error("drive active in recovery");
  a_ready_wait: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RECOV) |-> !servo_ready)
    else $error("ready during recovery");
  a_ready_back: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RECOV && !both_off && r.rdy_cnt >= `STO_CNT_W'(RDY_CYC - 1)) |=>
      servo_ready && r.state == STO_RUN) else $error("ready not restored");
  a_run_follow: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RUN && !both_off) |=> motor_energize == $past(son))
    else $error("energize not following servo on");
  a_brake_time: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_CUT && r.ms_cnt >= brake_action_delay_time) |=> !brake_release_output)
    else $error("brake not engaged after delay");
  a_display_blank: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state != STO_CUT) |-> seg_left == `STO_SEG_BLANK && seg_right == `STO_SEG_BLANK)
    else $error("display not blank");
  a_run_ready: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RUN) |-> servo_ready)
    else $error("not ready in run");
  a_run_no_cut: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RUN) |-> !safe_torque_cutoff)
    else $error("cutoff flag in run");
  a_run_seq: assert property (@(posedge mclk) disable iff (!nrst)
    (r.state == STO_RUN && $past(r.state) == STO_RUN) |->
      stop_sequence == $past(servo_off_stop_sequence))
    else $error("wrong run stop sequence");
endmodule

//--- core/sto_params.svh
`ifndef STO_PARAMS_SVH
`define STO_PARAMS_SVH
`define STO_CLK_HZ        25000000
`define STO_FILT_US       1000
`define STO_CUT_US        5000
`define STO_MON_US        6000
`define STO_RDY_US        20000
`define STO_CNT_W         20
`define STO_SPD_W         16
`define STO_TIM_W         16
`define STO_SEQ_W         3
`define STO_SEG_S         8'h6D
`define STO_SEG_T         8'h78
`define STO_SEG_BLANK     8'h00
`define STO_PIPE_CYC      4
`endif

//--- core/sto_pkg.sv
package sto_pkg;
  typedef enum logic [1:0] {
    STO_RUN   = 2'b00,
    STO_CUT   = 2'b01,
    STO_RECOV = 2'b10
  } sto_state_e;
endpackage

//--- tb/sto_partner.sv
`timescale 1ns/1ps
module sto_partner (
  input  wire logic mclk,
  input  wire logic cut_req,
  input  wire logic one_only,
  input  wire logic sv_req,
  output logic      safety_input_one = 1'b0,
  output logic      safety_input_two = 1'b0,
  output logic      servo_on_input   = 1'b0
);
  // one request feeds both channels so they never skew; one_only breaks that on purpose
  always @(posedge mclk) begin
    safety_input_one <= !(cut_req || one_only);
    safety_input_two <= !cut_req;
    servo_on_input   <= sv_req;
  end
endmodule

//--- tb/sto_seq_tb.sv
`timescale 1ns/1ps
`include "sto_params.svh"
module sto_seq_tb;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        cut_req = 1'b1;
  logic        one_only = 1'b0;
  logic        sv_req = 1'b0;
  logic [15:0] speed = 16'h0000;
  logic [2:0]  alm_seq = 3'h5;
  logic [2:0]  off_seq = 3'h2;
  logic        s1, s2, son, rdy, ener, mon, brk, cut, alm;
  logic [2:0]  seq;
  logic [7:0]  sl, sr;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  sto_partner sto_partner_i (.mclk(mclk), .cut_req(cut_req), .one_only(one_only),
    .sv_req(sv_req), .safety_input_one(s1), .safety_input_two(s2), .servo_on_input(son));
  // short counts keep the run brief: 10 cycle filter, 20 cycle ready, 5 cycles per ms
  sto_seq #(.FILT_CYC(10), .RDY_CYC(20), .TICK_CYC(5)) sto_seq_i (.mclk(mclk), .nrst(nrst),
    .safety_input_one(s1), .safety_input_two(s2), .servo_on_input(son), .motor_speed(speed),
    .brake_release_speed_threshold(16'h0100), .brake_action_delay_time(16'h0004),
    .alarm_stop_sequence(alm_seq), .servo_off_stop_sequence(off_seq), .servo_ready(rdy),
    .motor_energize(ener), .external_monitor_output(mon), .brake_release_output(brk),
    .safe_torque_cutoff(cut), .alarm_active(alm), .stop_sequence(seq), .seg_left(sl),
    .seg_right(sr));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      end_of_test();
    end
  end
  task end_of_test;
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // sample just after the edge so registered outputs have settled
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wait_cut(input logic v);
    for (int i = 0; i < 60 && cut !== v; i++) cyc(1);
  endtask
  task t_powerup;
    cyc(15);
    chk("cutoff", 1, cut);
    chk("ready", 0, rdy);
    chk("monitor", 1, mon);
    chk("alarm", 0, alm);
    chk("seg_left", 8'h6D, sl);
    chk("seg_right", 8'h78, sr);
    chk("energize", 0, ener);
    chk("sequence", alm_seq, seq);
  endtask
  task t_return;
    @(posedge mclk) cut_req <= 1'b0;
    cyc(10);
    chk("cutoff", 0, cut);
    chk("monitor", 0, mon);
    chk("sequence", off_seq, seq);
    chk("ready early", 0, rdy);
    cyc(25);
    chk("ready", 1, rdy);
    chk("alarm", 0, alm);
  endtask
  task t_glitch;
    @(posedge mclk) cut_req <= 1'b1;
    cyc(5);
    @(posedge mclk) cut_req <= 1'b0;
    cyc(30);
    chk("cutoff", 0, cut);
    chk("ready", 1, rdy);
  endtask
  task t_one;
    @(posedge mclk) one_only <= 1'b1;
    cyc(40);
    chk("cutoff", 0, cut);
    chk("monitor", 0, mon);
    @(posedge mclk) one_only <= 1'b0;
    cyc(5);
  endtask
  // servo-on stays high into the cutoff so the brake timing is seen
  task t_stop(input logic [15:0] sp, input logic early, input logic [2:0] as);
    @(posedge mclk);
    sv_req  <= 1'b1;
    alm_seq <= as;
    cyc(10);
    chk("energize", 1, ener);
    chk("brake", 1, brk);
    @(posedge mclk) speed <= sp;
    cut_req <= 1'b1;
    wait_cut(1);
    chk("cutoff", 1, cut);
    chk("ready", 0, rdy);
    chk("energize", 0, ener);
    chk("sequence", as, seq);
    chk("monitor", 1, mon);
    cyc(4);
    chk("brake early", early, brk);
    cyc(26);
    chk("brake", 0, brk);
    chk("sequence", as, seq);
    @(posedge mclk) sv_req <= 1'b0;
    cyc(5);
    @(posedge mclk) cut_req <= 1'b0;
    cyc(10);
    chk("sequence", off_seq, seq);
    cyc(30);
    chk("ready", 1, rdy);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_powerup();
    t_return();
    t_glitch();
    t_one();
    t_stop(16'h0200, 1'b1, 3'h5);
    t_stop(16'h0010, 1'b0, 3'h6);
    end_of_test();
  end
endmodule
